// File: hw/oc_port_timer.sv
// One port's overcurrent counter and cool-down timer
`timescale 1ns/10ps
module oc_port_timer
    import oc_timer_pkg::*;
(
    input  wire logic             sys_clk,     // System clock
    input  wire logic             rst,         // Sync reset, active high
    input  wire logic             clk_en,      // Freeze when low
    input  wire logic             tick,        // 1 ms strobe
    input  wire logic [CNT_W-1:0] limit,       // Selected time-out, ms
    input  wire logic             restart,     // Selection field changed
    input  wire logic             powered,     // Port power is on
    input  wire logic             startup_done, // Startup window expired
    input  wire logic             over_cut,    // Current at/above cut or folded back
    input  wire logic             cut_disable, // Fault timing disabled
    input  wire logic             turned_off,  // Power enable/reset/DC/fast shutdown off
    input  wire logic             cancel_cool, // Port reset or off/manual mode
    input  wire logic             semiauto,    // Semiauto mode
    input  wire logic             detect_en,   // Detect enable bit
    output logic                  fault_off,   // Pulse: remove port power
    output logic                  cooling,     // Cool-down running, power-on refused
    output logic                  redetect,    // Pulse: start detection
    output logic [CNT_W-1:0]      oc_count     // Counter value
);
    import oc_timer_pkg::*;

    logic [CNT_W-1:0] next_oc_count;
    logic [3:0]       decay, next_decay;
    logic [CNT_W-1:0] cool, next_cool;
    logic             next_cooling, next_fault_off, next_redetect;
    logic             active;

    // Counter and cool-down next state
    always_comb begin
        next_oc_count  = oc_count;
        next_decay     = decay;
        next_cool      = cool;
        next_cooling   = cooling;
        next_fault_off = 1'b0;
        next_redetect  = 1'b0;
        active         = powered && startup_done && !cut_disable; // R10
        if (turned_off || !powered) begin
            next_oc_count = '0; // R6
            next_decay    = '0;
        end else if (restart && oc_count != '0) begin
            next_oc_count = '0; // R7
            next_decay    = '0;
        end else if (active && tick) begin
            if (over_cut) begin
                next_decay = '0;
                if (oc_count + 1'b1 >= limit) begin
                    next_oc_count  = '0;
                    next_fault_off = 1'b1; // R3
                    next_cooling   = 1'b1; // R4
                    next_cool      = '0;
                end else begin
                    next_oc_count = oc_count + 1'b1; // R1
                end
            end else if (oc_count != '0) begin
                // Slow decay, floor at zero
                next_decay = decay + 1'b1; // R5
                if (decay == 4'(DECAY_DIV - 1)) begin
                    next_oc_count = oc_count - 1'b1; // R5
                end
            end
        end
        // Cool-down; cancel has priority over completion
        if (cooling && !next_fault_off) begin
            if (cancel_cool) begin
                next_cooling = 1'b0; // R9
            end else if (tick) begin
                if (cool == CNT_W'(COOL_DOWN_MS - 1)) begin
                    next_cooling  = 1'b0; // R4
                    next_redetect = semiauto && detect_en; // R8
                end else begin
                    next_cool = cool + 1'b1;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_count  <= '0;
            decay     <= '0;
            cool      <= '0;
            cooling   <= 1'b0;
            fault_off <= 1'b0;
            redetect  <= 1'b0;
        end else if (clk_en) begin
            oc_count  <= next_oc_count;
            decay     <= next_decay;
            cool      <= next_cool;
            cooling   <= next_cooling;
            fault_off <= next_fault_off;
            redetect  <= next_redetect;
        end
    end
endmodule // oc_port_timer

// File: hw/oc_timer_pkg.sv
// Constants shared by the per-port overcurrent fault timer
package oc_timer_pkg;
    localparam int          NUM_PORTS        = 8;
    localparam int          CLK_FREQ_HZ      = 125_000_000;
    // Time-out figures in milliseconds
    localparam int          TMO_SEL0_MS      = 60;
    localparam int          TMO_SEL1_MS      = 30;
    localparam int          TMO_SEL2_MS      = 120;
    localparam int          COOL_DOWN_MS     = 1000;
    // Counter tick of 1 ms; counts are in ticks
    localparam int          TICK_US          = 1000;
    localparam int          TICK_CYCLES      = (CLK_FREQ_HZ / 1_000_000) * TICK_US;
    localparam int          DECAY_DIV        = 16;
    // Timing configuration field layout
    localparam int          TSEL_LSB         = 2;
    localparam int          TSEL_W           = 2;
    localparam logic [7:0]  TIMING_CFG_RESET = 8'h00;
    localparam int          CNT_W            = 11;
    // Selection code to time-out in ms
    function automatic logic [CNT_W-1:0] tmo_ms(input logic [1:0] sel);
        case (sel)
            2'h1:    tmo_ms = CNT_W'(TMO_SEL1_MS);
            2'h2:    tmo_ms = CNT_W'(TMO_SEL2_MS);
            default: tmo_ms = CNT_W'(TMO_SEL0_MS);
        endcase
    endfunction
endpackage

// File: hw/port_overcurrent_fault_timer.sv
// Eight-port overcurrent fault timer with timing configuration register
// Functional notes
// [R1] Count up on overcurrent after startup window
// [R2] Two-bit select: 60, 30, 120 ms
// [R3] Reaching time-out switches port power off
// [R4] One-second cool-down blocks power-on
// [R5] Decrement at one-sixteenth rate, floor zero
// [R6] Clear counter whenever port turned off
// [R7] Select change restarts running counter
// [R8] Semiauto cool-down end restarts detection
// [R9] Reset command or off/manual cancels cool-down
// [R10] Cut-fault disable bit stops fault timing
// [R11] Eight independent counters, one shared select
`timescale 1ns/10ps
module port_overcurrent_fault_timer
    import oc_timer_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES // Cycles per 1 ms tick; a bench may shorten it
)
(
    input  wire logic                                sys_clk,             // System clock
    input  wire logic                                rst,                 // Sync reset
    input  wire logic                                clk_en,              // Freeze when low
    input  wire logic                                cfg_wr,              // Config write strobe
    input  wire logic [7:0]                          cfg_wdata,           // Config write data
    output logic [7:0]                               port_timing_configuration, // Config reg
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  powered,             // Port power on
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  startup_window,      // Window expired
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  overcurrent_cut_threshold, // Over cut
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  cut_fault_disable,   // Timing disabled
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  turned_off,          // Commanded off
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  cancel_cool,         // Reset or off/manual
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  semiauto,            // Semiauto mode
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  detect_en,           // Detect enable
    input  wire logic                                fast_shutdown_input, // Async pin
    input  wire logic [oc_timer_pkg::NUM_PORTS-1:0]  fast_shutdown_mask,  // Ports it sheds
    output logic [oc_timer_pkg::NUM_PORTS-1:0]       fault_off,           // Pulse: power off
    output logic [oc_timer_pkg::NUM_PORTS-1:0]       cooling,             // Power-on refused
    output logic [oc_timer_pkg::NUM_PORTS-1:0]       redetect             // Pulse: detect
);
    import oc_timer_pkg::*;

    logic [7:0]       next_cfg;
    logic             next_restart;
    logic [1:0]       overload_time_select;
    logic [CNT_W-1:0] limit;
    logic [16:0]      tick_cnt, next_tick_cnt;
    logic             tick;
    logic [2:0]       oss_sync, next_oss_sync;
    logic             oss_level, next_oss_level;

    // Register write; a write that changes the select restarts running counters.
    // Restart acts on the write edge itself, so no tick can meet a new
    // shorter limit with an old count and shed the port by mistake.
    always_comb begin
        next_cfg     = port_timing_configuration;
        next_restart = 1'b0;
        if (cfg_wr) begin
            next_cfg     = cfg_wdata;
            next_restart = cfg_wdata[TSEL_LSB +: TSEL_W] !=
                           port_timing_configuration[TSEL_LSB +: TSEL_W]; // R7
        end
    end

    // Reserved code 11 falls back to the default duration
    assign overload_time_select = port_timing_configuration[TSEL_LSB +: TSEL_W];
    assign limit                = tmo_ms(overload_time_select); // R2

    // Millisecond tick divider, shared so all ports age alike
    always_comb begin
        tick          = tick_cnt == 17'(TICK_LEN - 1);
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    // Fast shutdown pin: three stages, change accepted when last two agree
    always_comb begin
        next_oss_sync  = {oss_sync[1:0], fast_shutdown_input};
        next_oss_level = (oss_sync[2] == oss_sync[1]) ? oss_sync[2] : oss_level;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_timing_configuration <= TIMING_CFG_RESET; // R2
            tick_cnt                  <= '0;
            oss_sync                  <= '0;
            oss_level                 <= 1'b0;
        end else if (clk_en) begin
            port_timing_configuration <= next_cfg;
            tick_cnt                  <= next_tick_cnt;
            oss_sync                  <= next_oss_sync;
            oss_level                 <= next_oss_level;
        end
    end

    // One timer per port, shared select
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port // R11
        oc_port_timer u_timer (
            .sys_clk      (sys_clk),
            .rst          (rst),
            .clk_en       (clk_en),
            .tick         (tick),
            .limit        (limit),
            .restart      (next_restart), // R7
            .powered      (powered[p]),
            .startup_done (startup_window[p]),
            .over_cut     (overcurrent_cut_threshold[p]),
            .cut_disable  (cut_fault_disable[p]),
            .turned_off   (turned_off[p] | (oss_level & fast_shutdown_mask[p])), // R6
            .cancel_cool  (cancel_cool[p]),
            .semiauto     (semiauto[p]),
            .detect_en    (detect_en[p]),
            .fault_off    (fault_off[p]),
            .cooling      (cooling[p]),
            .redetect     (redetect[p]),
            .oc_count     ()
        );
    end
endmodule // port_overcurrent_fault_timer

// File: testbench/oc_fault_timer_asserts.sv
// Port assertions for the eight-port overcurrent fault timer
`timescale 1ns/10ps
module oc_fault_timer_asserts (
    input wire logic       sys_clk,                   // Clock
    input wire logic       rst,                       // Sync reset
    input wire logic       clk_en,                    // Clock enable
    input wire logic       cfg_wr,                    // Write strobe
    input wire logic [7:0] cfg_wdata,                 // Write data
    input wire logic [7:0] port_timing_configuration, // Register
    input wire logic [7:0] overcurrent_cut_threshold, // Over cut
    input wire logic [7:0] cut_fault_disable,         // Timing off
    input wire logic [7:0] semiauto,                  // Semiauto
    input wire logic [7:0] detect_en,                 // Detect enable
    input wire logic [7:0] fault_off,                 // Power-off pulse
    input wire logic [7:0] cooling,                   // Cool-down
    input wire logic [7:0] redetect                   // Detect pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Taken write; a frozen clock must not take it
    sequence s_wr; clk_en && cfg_wr; endsequence
    chk_reg_write: assert property (s_wr |=> port_timing_configuration == $past(cfg_wdata))
        else $error("config write not taken");
    chk_reg_hold: assert property (!cfg_wr |=> $stable(port_timing_configuration))
        else $error("config changed without write");
    chk_fault_pulse: assert property ($past(clk_en) |-> (fault_off & $past(fault_off)) == 8'h00)
        else $error("power-off pulse too long");
    chk_fault_cools: assert property ((fault_off & ~cooling) == 8'h00)
        else $error("power-off without cool-down");
    chk_redetect_end: assert property ($past(clk_en) |-> (redetect & ~$past(cooling)) == 8'h00)
        else $error("detect pulse outside cool-down end");
    chk_redetect_mode: assert property ($past(clk_en)
        |-> (redetect & ~($past(semiauto) & $past(detect_en))) == 8'h00)
        else $error("detect pulse in wrong mode");
    chk_disable_holds: assert property ($past(clk_en)
        |-> (fault_off & $past(cut_fault_disable)) == 8'h00)
        else $error("power-off with timing disabled");
    chk_fault_cause: assert property ($past(clk_en)
        |-> (fault_off & ~$past(overcurrent_cut_threshold)) == 8'h00)
        else $error("power-off without overcurrent");
endmodule // oc_fault_timer_asserts
bind port_overcurrent_fault_timer oc_fault_timer_asserts i_oc_fault_timer_asserts (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .port_timing_configuration(port_timing_configuration),
    .overcurrent_cut_threshold(overcurrent_cut_threshold),
    .cut_fault_disable(cut_fault_disable), .semiauto(semiauto), .detect_en(detect_en),
    .fault_off(fault_off), .cooling(cooling), .redetect(redetect));

// File: testbench/oc_port_partner.sv
// External power switch and powered device on each port
`timescale 1ns/10ps
module oc_port_partner (
    input  wire logic       sys_clk,     // Clock
    input  wire logic       rst,         // Sync reset
    input  wire logic [7:0] power_req,   // Host wants power on
    input  wire logic [7:0] overload,    // Load draws above cut
    input  wire logic [7:0] fault_off,   // Power-off pulse
    input  wire logic [7:0] cooling,     // Power-on refused
    output logic      [7:0] powered,     // Switch closed
    output logic      [7:0] startup_done // Startup window over
);
    // Switch opens on a fault pulse and stays open while refused
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powered      <= 8'h00;
            startup_done <= 8'h00;
        end else begin
            powered      <= power_req & ~fault_off & (powered | ~cooling);
            startup_done <= powered & power_req;
        end
    end
endmodule // oc_port_partner

// File: testbench/tb_port_overcurrent_fault_timer.sv
// Testbench for the eight-port overcurrent fault timer
`timescale 1ns/10ps
module tb_port_overcurrent_fault_timer;
    import oc_timer_pkg::*;
    logic       sys_clk, rst, clk_en, cfg_wr, fsd;
    logic [7:0] cfg_wdata, reg_q, pwr, stw, dis, toff, ccl, semi, den, fmask, req, ovl;
    logic [7:0] fault_off, cooling, redetect;
    int         miscompares, n_tests, n;
    // Short tick so time-outs and the cool-down fit the cycle budget
    localparam int TK = 10;
    port_overcurrent_fault_timer #(.TICK_LEN(TK)) i_port_overcurrent_fault_timer (
        .sys_clk(sys_clk),
        .rst(rst), .clk_en(clk_en), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .port_timing_configuration(reg_q), .powered(pwr), .startup_window(stw),
        .overcurrent_cut_threshold(ovl & pwr), .cut_fault_disable(dis), .turned_off(toff),
        .cancel_cool(ccl), .semiauto(semi), .detect_en(den), .fast_shutdown_input(fsd),
        .fast_shutdown_mask(fmask), .fault_off(fault_off), .cooling(cooling),
        .redetect(redetect));
    oc_port_partner i_oc_port_partner (.sys_clk(sys_clk), .rst(rst), .power_req(req),
        .overload(ovl), .fault_off(fault_off), .cooling(cooling), .powered(pwr),
        .startup_done(stw));
    // Free-running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobe held one full cycle so exactly one edge takes it
    task automatic write_cfg(input logic [7:0] d, input logic [7:0] exp);
        @(negedge sys_clk);
        cfg_wr    = 1'b1;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        check(reg_q, exp);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // A bound that runs out counts as a mismatch and ends the run
    task automatic give_up(input string what);
        miscompares++;
        $display("ERROR %0t: %s timed out", $time, what);
        print_verdict();
    endtask
    // Cycles until a power-off pulse shows, counted in n
    task automatic wait_fault(input int lim);
        for (n = 0; n < lim && fault_off === 8'h00; n++) @(negedge sys_clk);
        if (fault_off === 8'h00) give_up("power-off wait");
    endtask
    // Drop the load and cancel the cool-down of the ports just shed
    task automatic cancel_cd(input logic [7:0] m);
        ovl = 8'h00;
        ccl = m;
        @(negedge sys_clk);
        ccl = 8'h00;
        check(cooling, 8'h00);
        check(redetect, 8'h00);
    endtask
    initial begin
        miscompares = 0;
        n_tests = 0;
        {rst, clk_en, cfg_wr, fsd} = 4'b1100;
        {cfg_wdata, dis, toff, ccl, semi, den, fmask, req, ovl} = '0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        check(reg_q, TIMING_CFG_RESET);
        check(fault_off | cooling | redetect, 8'h00);
        // Every select code, other bits kept as written
        for (int s = 0; s < 4; s++) write_cfg({4'ha, s[1:0], 2'h1}, {4'ha, s[1:0], 2'h1});
        // A frozen clock takes no write
        clk_en = 1'b0;
        write_cfg(8'h08, {4'ha, 2'h3, 2'h1});
        clk_en = 1'b1;
        // Code 11 runs as 60 ticks; ports 0-3 timing off, 4-7 shed together
        {req, ovl, semi, den, dis} = {8'hff, 8'hff, 8'hff, 8'h30, 8'h0f};
        wait_fault(62 * TK);
        check(fault_off, 8'hf0);
        check(8'(n >= 59 * TK && n <= 61 * TK), 8'h01);
        check(cooling, 8'hf0);
        ovl = 8'h00;
        repeat (2) @(negedge sys_clk);
        check(pwr, 8'h0f);
        // Refused for exactly 1000 ticks, then detection restarts where enabled
        repeat (990 * TK) @(negedge sys_clk);
        check(cooling, 8'hf0);
        for (n = 0; n < 20 * TK && cooling !== 8'h00; n++) @(negedge sys_clk);
        if (cooling !== 8'h00) give_up("cool-down end");
        check(8'(n >= 10 * TK - 3 && n <= 10 * TK - 1), 8'h01);
        check(redetect, 8'h30);
        // Port 4: 40 ticks up, 160 down take off ten, so 30 more trip it
        ovl = 8'h10;
        repeat (40 * TK) @(negedge sys_clk);
        ovl = 8'h00;
        repeat (160 * TK) @(negedge sys_clk);
        ovl = 8'h10;
        wait_fault(40 * TK);
        check(fault_off, 8'h10);
        check(8'(n >= 27 * TK && n <= 34 * TK), 8'h01);
        cancel_cd(8'h10);
        // Port 5 at 40 of 60; switching to 30 restarts it from zero
        ovl = 8'h20;
        repeat (40 * TK) @(negedge sys_clk);
        write_cfg(8'h04, 8'h04);
        wait_fault(35 * TK);
        check(fault_off, 8'h20);
        check(8'(n >= 28 * TK && n <= 31 * TK), 8'h01);
        cancel_cd(8'h20);
        // Ports 6, 7 at 20 of 30; power-enable off clears 6, fast shutdown 7
        ovl = 8'hc0;
        repeat (20 * TK) @(negedge sys_clk);
        {toff, fmask, fsd} = {8'h40, 8'h80, 1'b1};
        repeat (4) @(negedge sys_clk);
        {toff, fsd} = {8'h00, 1'b0};
        repeat (4) @(negedge sys_clk);
        wait_fault(35 * TK);
        check(8'(n >= 28 * TK && n <= 32 * TK), 8'h01);
        repeat (2 * TK) @(negedge sys_clk);
        check(cooling, 8'hc0);
        cancel_cd(8'hc0);
        print_verdict();
    end
endmodule // tb_port_overcurrent_fault_timer
